// ===== verilog/mhrb_pkg.sv
package mhrb_pkg;
   // Word addresses of the holding registers
   localparam logic [7:0] ADDR_FIRST      = 8'h70;
   localparam logic [7:0] ADDR_ERR_HI     = 8'h70;
   localparam logic [7:0] ADDR_ERR_LO     = 8'h71;
   localparam logic [7:0] ADDR_CAL_A      = 8'h79;
   localparam logic [7:0] ADDR_CAL_B      = 8'h7a;
   localparam logic [7:0] ADDR_CAL_CLEAR  = 8'h7d;
   localparam logic [7:0] ADDR_GAS_HI     = 8'h7e;
   localparam logic [7:0] ADDR_GAS_LO     = 8'h7f;
   localparam logic [7:0] ADDR_DATE_HI    = 8'h80;
   localparam logic [7:0] ADDR_DATE_LO    = 8'h81;
   localparam logic [7:0] ADDR_NAME_FIRST = 8'h88;
   localparam logic [7:0] ADDR_NAME_LAST  = 8'h8f;
   localparam logic [7:0] ADDR_SLOPE_HI   = 8'h90;
   localparam logic [7:0] ADDR_SLOPE_LO   = 8'h91;
   localparam logic [7:0] ADDR_OFFS_HI    = 8'h92;
   localparam logic [7:0] ADDR_OFFS_LO    = 8'h93;
   localparam logic [7:0] ADDR_EDIT       = 8'h94;
   localparam logic [7:0] ADDR_BUS_ADDR   = 8'h96;
   localparam logic [7:0] ADDR_MODE       = 8'h97;
   localparam logic [7:0] ADDR_LIQUID     = 8'h98;
   localparam logic [7:0] ADDR_FRAMING    = 8'h9f;
   localparam logic [7:0] ADDR_BAUD       = 8'ha0;
   localparam logic [7:0] ADDR_TIME_0     = 8'haf;
   localparam logic [7:0] ADDR_TIME_1     = 8'hb0;
   localparam logic [7:0] ADDR_TIME_2     = 8'hb1;
   localparam logic [7:0] ADDR_TIME_3     = 8'hb2;
   localparam logic [7:0] ADDR_RESTART    = 8'hc5;
   localparam logic [7:0] ADDR_OWNER      = 8'hc9;
   localparam logic [7:0] ADDR_SITE       = 8'hd3;
   localparam logic [7:0] ADDR_ASSET      = 8'hdd;
   localparam logic [7:0] ADDR_TEXT_LAST  = 8'he6;
   localparam int         TEXT_COUNT      = 3;
   localparam int         TEXT_WORDS      = 10;
   localparam int         NAME_WORDS      = 8;
   localparam int         IDX_W           = 4;
   // Edit window commands
   localparam logic [15:0] EDIT_OPEN      = 16'h0001;
   localparam logic [15:0] EDIT_SAVE      = 16'h0002;
   localparam logic [15:0] EDIT_ABORT     = 16'h0003;
   // Legal value ranges
   localparam logic [15:0] BUS_ADDR_MIN   = 16'h0001;
   localparam logic [15:0] BUS_ADDR_MAX   = 16'h00f7;
   localparam logic [15:0] MODE_MAX       = 16'h0001;
   localparam logic [15:0] LIQUID_MAX     = 16'h0003;
   localparam logic [15:0] CODE_MIN       = 16'h0001;
   localparam logic [15:0] CODE_MAX       = 16'h0006;
   // Values after reset
   localparam logic [15:0] FRAMING_RESET  = 16'h0001;
   localparam logic [7:0]  BAUD_RESET     = 8'h03;
   localparam logic [7:0]  BUS_ADDR_RESET = 8'h01;
   // Answer codes
   localparam logic [7:0] EXC_NONE        = 8'h00;
   localparam logic [7:0] EXC_ADDRESS     = 8'h02;
   localparam logic [7:0] EXC_VALUE       = 8'h03;
endpackage

// ===== verilog/mhrb_str_if.sv
interface mhrb_str_if #(
   parameter int WORDS = 10
);
   logic                     wrEn;
   logic [3:0]               idx;
   logic [15:0]              wrData;
   logic                     restart;
   logic [15:0]              rdData;
   logic [WORDS*16-1:0]      text;

   modport bank  (output wrEn, output idx, output wrData, output restart, input rdData, input text);
   modport store (input wrEn, input idx, input wrData, input restart, output rdData, output text);
endinterface

// ===== verilog/mhrb_string_store.sv
module mhrb_string_store #(
   parameter int WORDS = 10
) (
   input  wire logic  clock,
   input  wire logic  resetn,
   mhrb_str_if.store  port
);
   typedef struct packed {
      logic [WORDS-1:0][15:0] stage;
      logic [WORDS-1:0][15:0] text;
      logic                   lowSeen;
      logic                   highSeen;
   } mhrb_store_state_t;

   mhrb_store_state_t s;
   mhrb_store_state_t next_s;

   generate
      if (WORDS < 2 || WORDS > 15) begin : g_bad
         $error("mhrb_string_store: WORDS must be 2 to 15");
      end
   endgenerate

   // Staged words become visible only once both ends are written
   always_comb begin
      next_s = s;
      if (port.restart) begin
         next_s = '0;
      end else if (port.wrEn && port.idx < 4'(WORDS)) begin
         // Lowest address lands in the top word, matching the read side
         next_s.stage[4'(WORDS - 1) - port.idx] = port.wrData;
         if (port.idx == '0) next_s.lowSeen = 1'b1;
         if (port.idx == 4'(WORDS - 1)) next_s.highSeen = 1'b1;
         if (next_s.lowSeen && next_s.highSeen) begin
            next_s.text         = next_s.stage;
            next_s.text[0][7:0] = 8'h00;
            next_s.lowSeen      = 1'b0;
            next_s.highSeen     = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) s <= '0;
      else s <= next_s;
   end

   // Word 0 sits in the top bits, first character in its high byte
   assign port.rdData = (port.idx < 4'(WORDS)) ? s.text[4'(WORDS - 1) - port.idx] : 16'h0000;
   assign port.text   = s.text;
endmodule

// ===== verilog/mhrb_bank.sv
module mhrb_bank (
   input  wire logic           clock,
   input  wire logic           resetn,
   input  wire logic           reqValid,
   input  wire logic           reqWrite,
   input  wire logic [7:0]     reqAddr,
   input  wire logic [15:0]    reqData,
   output logic                rspValid,
   output logic [15:0]         rspData,
   output logic [7:0]          rspExc,
   input  wire logic [31:0]    errorFlags,
   output logic                firstCalibrationCommand,
   output logic                secondCalibrationCommand,
   output logic                clearGasCalibrationCommand,
   output logic [31:0]         calibrationGasLevel,
   output logic [31:0]         calibrationDate,
   output logic [127:0]        liquidName,
   output logic [31:0]         solubilitySlope,
   output logic [31:0]         solubilityOffset,
   output logic                editOpen,
   output logic [7:0]          busAddress,
   output logic                labMode,
   output logic [15:0]         liquidSelect,
   output logic [15:0]         serialFraming,
   output logic [7:0]          serialBitRate,
   output logic [63:0]         clockTime,
   output logic                unitRestart,
   output logic [159:0]        ownerText,
   output logic [159:0]        siteText,
   output logic [159:0]        assetText
);
   typedef struct packed {
      logic           rspValid;
      logic [15:0]    rspData;
      logic [7:0]     rspExc;
      logic           calA;
      logic           calB;
      logic           calClear;
      logic [31:0]    gas;
      logic [31:0]    date;
      logic [127:0]   name;
      logic [127:0]   nameShadow;
      logic [31:0]    slope;
      logic [31:0]    slopeShadow;
      logic [31:0]    offs;
      logic [31:0]    offsShadow;
      logic           editOpen;
      logic [7:0]     busAddr;
      logic [15:0]    mode;
      logic [15:0]    liquidSel;
      logic [15:0]    framing;
      logic [7:0]     baud;
      logic [63:0]    timeVal;
      logic           restartPend;
      logic           restart;
      logic [47:0]    rdLatch;
      logic [7:0]     rdBase;
      logic           rdLatchValid;
      logic [47:0]    wrHold;
      logic [7:0]     wrBase;
      logic           wrHoldValid;
   } mhrb_bank_state_t;

   localparam mhrb_bank_state_t RESET_STATE = '{
      framing: mhrb_pkg::FRAMING_RESET,
      baud:    mhrb_pkg::BAUD_RESET,
      busAddr: mhrb_pkg::BUS_ADDR_RESET,
      default: '0
   };

   mhrb_bank_state_t s;
   mhrb_bank_state_t next_s;

   logic [127:0]                       nameView;
   logic [31:0]                        slopeView;
   logic [31:0]                        offsView;
   logic [15:0]                        liveData;
   logic [47:0]                        latchData;
   logic [7:0]                         base;
   logic [7:0]                         pos;
   logic                               strHit;
   logic [1:0]                         strSel;
   logic [7:0]                         strOff;
   logic [mhrb_pkg::TEXT_COUNT-1:0][15:0]  strRd;
   logic [mhrb_pkg::TEXT_COUNT-1:0][159:0] strText;
   logic                               accept;

   mhrb_str_if #(.WORDS(mhrb_pkg::TEXT_WORDS)) strIf[mhrb_pkg::TEXT_COUNT] ();

   // First word of a multiword group, zero when the address stands alone
   function automatic logic [7:0] grpBase(input logic [7:0] a);
      case (a)
         mhrb_pkg::ADDR_ERR_HI,   mhrb_pkg::ADDR_ERR_LO:   grpBase = mhrb_pkg::ADDR_ERR_HI;
         mhrb_pkg::ADDR_GAS_HI,   mhrb_pkg::ADDR_GAS_LO:   grpBase = mhrb_pkg::ADDR_GAS_HI;
         mhrb_pkg::ADDR_DATE_HI,  mhrb_pkg::ADDR_DATE_LO:  grpBase = mhrb_pkg::ADDR_DATE_HI;
         mhrb_pkg::ADDR_SLOPE_HI, mhrb_pkg::ADDR_SLOPE_LO: grpBase = mhrb_pkg::ADDR_SLOPE_HI;
         mhrb_pkg::ADDR_OFFS_HI,  mhrb_pkg::ADDR_OFFS_LO:  grpBase = mhrb_pkg::ADDR_OFFS_HI;
         mhrb_pkg::ADDR_TIME_0, mhrb_pkg::ADDR_TIME_1,
         mhrb_pkg::ADDR_TIME_2, mhrb_pkg::ADDR_TIME_3:     grpBase = mhrb_pkg::ADDR_TIME_0;
         default:                                          grpBase = 8'h00;
      endcase
   endfunction

   // Host sees its own edits while the window is open
   assign nameView  = s.editOpen ? s.nameShadow  : s.name;
   assign slopeView = s.editOpen ? s.slopeShadow : s.slope;
   assign offsView  = s.editOpen ? s.offsShadow  : s.offs;
   assign base      = grpBase(reqAddr);
   assign pos       = reqAddr - base;
   assign accept    = reqValid && !s.restartPend && !s.restart;

   // Identification string decode by range, avoiding a divider
   always_comb begin
      strHit = (reqAddr >= mhrb_pkg::ADDR_OWNER) && (reqAddr <= mhrb_pkg::ADDR_TEXT_LAST);
      if (reqAddr >= mhrb_pkg::ADDR_ASSET) begin
         strSel = 2'd2;
         strOff = reqAddr - mhrb_pkg::ADDR_ASSET;
      end else if (reqAddr >= mhrb_pkg::ADDR_SITE) begin
         strSel = 2'd1;
         strOff = reqAddr - mhrb_pkg::ADDR_SITE;
      end else begin
         strSel = 2'd0;
         strOff = reqAddr - mhrb_pkg::ADDR_OWNER;
      end
   end

   // One store per identification string
   generate
      for (genvar g = 0; g < mhrb_pkg::TEXT_COUNT; g++) begin : g_text
         assign strIf[g].wrEn    = accept && reqWrite && strHit && (strSel == 2'(g));
         assign strIf[g].idx     = strOff[3:0];
         assign strIf[g].wrData  = reqData;
         assign strIf[g].restart = s.restart;
         assign strRd[g]         = strIf[g].rdData;
         assign strText[g]       = strIf[g].text;
         mhrb_string_store #(.WORDS(mhrb_pkg::TEXT_WORDS)) u_store (
            .clock  (clock),
            .resetn (resetn),
            .port   (strIf[g])
         );
      end
   endgenerate

   // Live read value; reserved words and command registers read zero, except the edit register, which reads the window state
   always_comb begin
      liveData = 16'h0000;
      case (reqAddr)
         mhrb_pkg::ADDR_ERR_HI:   liveData = errorFlags[31:16];
         mhrb_pkg::ADDR_ERR_LO:   liveData = errorFlags[15:0];
         mhrb_pkg::ADDR_GAS_HI:   liveData = s.gas[31:16];
         mhrb_pkg::ADDR_GAS_LO:   liveData = s.gas[15:0];
         mhrb_pkg::ADDR_DATE_HI:  liveData = s.date[31:16];
         mhrb_pkg::ADDR_DATE_LO:  liveData = s.date[15:0];
         mhrb_pkg::ADDR_SLOPE_HI: liveData = slopeView[31:16];
         mhrb_pkg::ADDR_SLOPE_LO: liveData = slopeView[15:0];
         mhrb_pkg::ADDR_OFFS_HI:  liveData = offsView[31:16];
         mhrb_pkg::ADDR_OFFS_LO:  liveData = offsView[15:0];
         mhrb_pkg::ADDR_EDIT:     liveData = {15'h0000, s.editOpen};
         mhrb_pkg::ADDR_BUS_ADDR: liveData = {8'h00, s.busAddr};
         mhrb_pkg::ADDR_MODE:     liveData = s.mode;
         mhrb_pkg::ADDR_LIQUID:   liveData = s.liquidSel;
         mhrb_pkg::ADDR_FRAMING:  liveData = s.framing;
         mhrb_pkg::ADDR_BAUD:     liveData = {8'h00, s.baud};
         mhrb_pkg::ADDR_TIME_0:   liveData = s.timeVal[63:48];
         mhrb_pkg::ADDR_TIME_1:   liveData = s.timeVal[47:32];
         mhrb_pkg::ADDR_TIME_2:   liveData = s.timeVal[31:16];
         mhrb_pkg::ADDR_TIME_3:   liveData = s.timeVal[15:0];
         default: begin
            if (reqAddr >= mhrb_pkg::ADDR_NAME_FIRST && reqAddr <= mhrb_pkg::ADDR_NAME_LAST) begin
               liveData = nameView[127 - 16 * (reqAddr - mhrb_pkg::ADDR_NAME_FIRST) -: 16];
            end else if (strHit) begin
               liveData = strRd[strSel];
            end
         end
      endcase
   end

   // Lower words captured by a high-word read
   always_comb begin
      case (base)
         mhrb_pkg::ADDR_ERR_HI:   latchData = {errorFlags[15:0], 32'h0000_0000};
         mhrb_pkg::ADDR_GAS_HI:   latchData = {s.gas[15:0], 32'h0000_0000};
         mhrb_pkg::ADDR_DATE_HI:  latchData = {s.date[15:0], 32'h0000_0000};
         mhrb_pkg::ADDR_SLOPE_HI: latchData = {slopeView[15:0], 32'h0000_0000};
         mhrb_pkg::ADDR_OFFS_HI:  latchData = {offsView[15:0], 32'h0000_0000};
         mhrb_pkg::ADDR_TIME_0:   latchData = s.timeVal[47:0];
         default:                 latchData = 48'h0000_0000_0000;
      endcase
   end

   // Request handling; the answer leaves one clock after the request
   always_comb begin
      next_s          = s;
      next_s.rspValid = 1'b0;
      next_s.calA     = 1'b0;
      next_s.calB     = 1'b0;
      next_s.calClear = 1'b0;
      next_s.restart  = 1'b0;
      if (s.restartPend) begin
         next_s         = RESET_STATE;
         next_s.restart = 1'b1;
      end else if (accept) begin
         next_s.rspValid = 1'b1;
         next_s.rspExc   = mhrb_pkg::EXC_NONE;
         next_s.rspData  = 16'h0000;
         if (reqAddr < mhrb_pkg::ADDR_FIRST) begin
            next_s.rspExc = mhrb_pkg::EXC_ADDRESS;
         end else if (!reqWrite) begin
            next_s.rspData = liveData;
            if (base != 8'h00 && pos != 8'h00 && s.rdLatchValid && s.rdBase == base) begin
               next_s.rspData = s.rdLatch[47 - 16 * (pos - 8'd1) -: 16];
            end
            if (base != 8'h00 && pos == 8'h00) begin
               next_s.rdLatch      = latchData;
               next_s.rdBase       = base;
               next_s.rdLatchValid = 1'b1;
            end
         end else begin
            case (reqAddr)
               mhrb_pkg::ADDR_CAL_A:     next_s.calA     = 1'b1;
               mhrb_pkg::ADDR_CAL_B:     next_s.calB     = 1'b1;
               mhrb_pkg::ADDR_CAL_CLEAR: next_s.calClear = 1'b1;
               mhrb_pkg::ADDR_ERR_HI, mhrb_pkg::ADDR_ERR_LO:
                  next_s.rspExc = mhrb_pkg::EXC_ADDRESS;
               mhrb_pkg::ADDR_GAS_HI, mhrb_pkg::ADDR_DATE_HI, mhrb_pkg::ADDR_SLOPE_HI, mhrb_pkg::ADDR_OFFS_HI,
               mhrb_pkg::ADDR_TIME_0, mhrb_pkg::ADDR_TIME_1, mhrb_pkg::ADDR_TIME_2: begin
                  // Stage a high word until the last word arrives
                  if ((base == mhrb_pkg::ADDR_SLOPE_HI || base == mhrb_pkg::ADDR_OFFS_HI) && !s.editOpen) begin
                     next_s.rspExc = mhrb_pkg::EXC_VALUE;
                  end else if (pos == 8'h00 || (s.wrHoldValid && s.wrBase == base)) begin
                     next_s.wrHold[47 - 16 * pos -: 16] = reqData;
                     next_s.wrBase      = base;
                     next_s.wrHoldValid = 1'b1;
                  end else begin
                     next_s.rspExc = mhrb_pkg::EXC_VALUE;
                  end
               end
               mhrb_pkg::ADDR_GAS_LO, mhrb_pkg::ADDR_DATE_LO, mhrb_pkg::ADDR_SLOPE_LO, mhrb_pkg::ADDR_OFFS_LO,
               mhrb_pkg::ADDR_TIME_3: begin
                  // Apply the whole value only with its staged high part
                  if ((base == mhrb_pkg::ADDR_SLOPE_HI || base == mhrb_pkg::ADDR_OFFS_HI) && !s.editOpen) begin
                     next_s.rspExc = mhrb_pkg::EXC_VALUE;
                  end else if (s.wrHoldValid && s.wrBase == base) begin
                     next_s.wrHoldValid = 1'b0;
                     case (base)
                        mhrb_pkg::ADDR_GAS_HI:   next_s.gas         = {s.wrHold[47:32], reqData};
                        mhrb_pkg::ADDR_DATE_HI:  next_s.date        = {s.wrHold[47:32], reqData};
                        mhrb_pkg::ADDR_SLOPE_HI: next_s.slopeShadow = {s.wrHold[47:32], reqData};
                        mhrb_pkg::ADDR_OFFS_HI:  next_s.offsShadow  = {s.wrHold[47:32], reqData};
                        default:                 next_s.timeVal     = {s.wrHold, reqData};
                     endcase
                  end else begin
                     next_s.rspExc = mhrb_pkg::EXC_VALUE;
                  end
               end
               mhrb_pkg::ADDR_EDIT: begin
                  case (reqData)
                     mhrb_pkg::EDIT_OPEN: begin
                        next_s.nameShadow  = s.name;
                        next_s.slopeShadow = s.slope;
                        next_s.offsShadow  = s.offs;
                        next_s.editOpen    = 1'b1;
                     end
                     mhrb_pkg::EDIT_SAVE: begin
                        if (s.editOpen) begin
                           next_s.name      = {s.nameShadow[127:8], 8'h00};
                           next_s.slope     = s.slopeShadow;
                           next_s.offs      = s.offsShadow;
                        end
                        next_s.editOpen = 1'b0;
                     end
                     mhrb_pkg::EDIT_ABORT: next_s.editOpen = 1'b0;
                     default:              next_s.rspExc   = mhrb_pkg::EXC_VALUE;
                  endcase
               end
               mhrb_pkg::ADDR_BUS_ADDR: begin
                  if (reqData >= mhrb_pkg::BUS_ADDR_MIN && reqData <= mhrb_pkg::BUS_ADDR_MAX) begin
                     next_s.busAddr = reqData[7:0];
                  end else begin
                     next_s.rspExc = mhrb_pkg::EXC_VALUE;
                  end
               end
               mhrb_pkg::ADDR_MODE: begin
                  if (reqData <= mhrb_pkg::MODE_MAX) next_s.mode = reqData;
                  else next_s.rspExc = mhrb_pkg::EXC_VALUE;
               end
               mhrb_pkg::ADDR_LIQUID: begin
                  if (reqData <= mhrb_pkg::LIQUID_MAX) next_s.liquidSel = reqData;
                  else next_s.rspExc = mhrb_pkg::EXC_VALUE;
               end
               mhrb_pkg::ADDR_FRAMING: begin
                  if (reqData >= mhrb_pkg::CODE_MIN && reqData <= mhrb_pkg::CODE_MAX) next_s.framing = reqData;
                  else next_s.rspExc = mhrb_pkg::EXC_VALUE;
               end
               mhrb_pkg::ADDR_BAUD: begin
                  if (reqData >= mhrb_pkg::CODE_MIN && reqData <= mhrb_pkg::CODE_MAX) next_s.baud = reqData[7:0];
                  else next_s.rspExc = mhrb_pkg::EXC_VALUE;
               end
               mhrb_pkg::ADDR_RESTART: next_s.restartPend = 1'b1;
               default: begin
                  // Name words only change inside the edit window
                  if (reqAddr >= mhrb_pkg::ADDR_NAME_FIRST && reqAddr <= mhrb_pkg::ADDR_NAME_LAST) begin
                     if (s.editOpen) begin
                        next_s.nameShadow[127 - 16 * (reqAddr - mhrb_pkg::ADDR_NAME_FIRST) -: 16] = reqData;
                     end else begin
                        next_s.rspExc = mhrb_pkg::EXC_VALUE;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) s <= RESET_STATE;
      else s <= next_s;
   end

   // Outputs straight from the state flops
   assign rspValid                   = s.rspValid;
   assign rspData                    = s.rspData;
   assign rspExc                     = s.rspExc;
   assign firstCalibrationCommand    = s.calA;
   assign secondCalibrationCommand   = s.calB;
   assign clearGasCalibrationCommand = s.calClear;
   assign calibrationGasLevel        = s.gas;
   assign calibrationDate            = s.date;
   assign liquidName                 = s.name;
   assign solubilitySlope            = s.slope;
   assign solubilityOffset           = s.offs;
   assign editOpen                   = s.editOpen;
   assign busAddress                 = s.busAddr;
   assign labMode                    = s.mode[0];
   assign liquidSelect               = s.liquidSel;
   assign serialFraming              = s.framing;
   assign serialBitRate              = s.baud;
   assign clockTime                  = s.timeVal;
   assign unitRestart                = s.restart;
   assign ownerText                  = strText[0];
   assign siteText                   = strText[1];
   assign assetText                  = strText[2];
endmodule

// ===== bench/mhrb_props.sv
module mhrb_props (
   input wire logic        clock, resetn, reqValid, reqWrite, rspValid, firstCalibrationCommand, labMode, unitRestart,
   input wire logic [7:0]  reqAddr, rspExc, busAddress, serialBitRate,
   input wire logic [15:0] reqData, serialFraming
);
   timeunit 1ns;
   timeprecision 1ns;
   wire wr = reqValid && reqWrite;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   property p_cal; wr && reqAddr == 8'h79 |=> firstCalibrationCommand ##1 !firstCalibrationCommand; endproperty
   a_cal: assert property (p_cal) else $error("cal pulse");
   property p_edit; wr && reqAddr == 8'h94 && reqData > 16'h3 |=> rspExc == 8'h03; endproperty
   a_edit: assert property (p_edit) else $error("edit code");
   property p_mode; wr && reqAddr == 8'h97 && reqData < 16'h2 |=> labMode == $past(reqData[0]); endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_frm; wr && reqAddr == 8'h9f && reqData inside {[1:6]} |=> serialFraming == $past(reqData); endproperty
   a_frm: assert property (p_frm) else $error("framing");
   property p_baud; wr && reqAddr == 8'ha0 && reqData inside {[1:6]} |=> serialBitRate == $past(reqData[7:0]); endproperty
   a_baud: assert property (p_baud) else $error("baud");
   property p_bad; wr && reqAddr == 8'ha0 && !(reqData inside {[1:6]}) |=> rspExc == 3 && $stable(serialBitRate); endproperty
   a_bad: assert property (p_bad) else $error("bad baud");
   property p_addr; wr && reqAddr == 8'h96 && !(reqData inside {[1:247]}) |=> rspExc == 3 && $stable(busAddress); endproperty
   a_addr: assert property (p_addr) else $error("unit address");
   property p_rst; wr && reqAddr == 8'hc5 |=> rspValid ##1 unitRestart && busAddress == 8'h01; endproperty
   a_rst: assert property (p_rst) else $error("restart");
   c_cal: cover property (firstCalibrationCommand);
   c_lab: cover property (labMode);
   c_rst: cover property (unitRestart);
endmodule
bind mhrb_bank mhrb_props u_props (.*);

// ===== bench/mhrb_host.sv
module mhrb_host (
   input  wire logic   clock,
   output logic [25:0] rq
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rq = 26'h0;
   // Released lines show the inverse, never a stale value
   task automatic req(input logic [25:0] r);
      @(negedge clock) rq = r;
      @(negedge clock) rq = {1'b0, ~r[24:0]};
   endtask
endmodule

// ===== bench/mhrb_bank_tb.sv
module mhrb_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clock = 1'b0, resetn = 1'b0, rspValid, labMode;
   logic [7:0]   rspExc, busAddress, serialBitRate;
   logic [15:0]  rspData, w[8];
   logic [25:0]  rq;
   logic [31:0]  errorFlags = 32'h0, seed = 32'h4c;
   logic [127:0] liquidName;
   logic [159:0] ownerText, e;
   logic [23:0]  q[$];
   int           err_count = 0, total_checks = 0, i;
   mhrb_host u_host (.clock, .rq);
   mhrb_bank u_dut (.clock, .resetn, .reqValid(rq[25]), .reqWrite(rq[24]), .reqAddr(rq[23:16]), .reqData(rq[15:0]),
      .rspValid, .rspData, .rspExc, .errorFlags, .firstCalibrationCommand(), .secondCalibrationCommand(),
      .clearGasCalibrationCommand(), .calibrationGasLevel(), .calibrationDate(), .liquidName, .solubilitySlope(),
      .solubilityOffset(), .editOpen(), .busAddress, .labMode, .liquidSelect(), .serialFraming(), .serialBitRate,
      .clockTime(), .unitRestart(), .ownerText, .siteText(), .assetText());
   initial forever #5 clock = ~clock;
   function automatic logic [15:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic chk(input logic [159:0] x, input logic [159:0] g);
      total_checks++;
      if (x !== g) err_count++;
      if (x !== g) $display("Error %0t: got %h want %h", $time, g, x);
   endtask
   // Expected answer {exc, data} is queued before the request goes out
   task automatic op(input logic wn, input logic [7:0] a, input logic [15:0] d, input logic [23:0] x);
      q.push_back(x);
      u_host.req({1'b1, wn, a, d});
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Answers stand one cycle; an unexpected one meets an unknown note
   always @(negedge clock) if (rspValid === 1'b1) chk(q.size() > 0 ? q.pop_front() : 24'hx, {rspExc, rspData});
   initial begin
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      op(0, 8'ha0, 16'h0, 24'h3);
      op(0, 8'h9f, 16'h0, 24'h1);
      for (i = 1; i < 8; i++) begin
         op(1, 8'ha0, 16'(i), i < 7 ? 24'h0 : 24'h30000);
         op(1, 8'h9f, 16'(i), i < 7 ? 24'h0 : 24'h30000);
      end
      errorFlags = {rnd(), rnd()};
      e = 160'(errorFlags);
      op(0, 8'h70, 16'h0, {8'h0, e[31:16]});
      errorFlags = ~errorFlags;
      op(0, 8'h71, 16'h0, {8'h0, e[15:0]});
      // Low half alone is refused; high then low applies both
      op(1, 8'h7f, 16'h5678, 24'h30000);
      op(1, 8'h7e, 16'h1234, 24'h0);
      op(1, 8'h7f, 16'h5678, 24'h0);
      op(0, 8'h7e, 16'h0, 24'h1234);
      op(0, 8'h7f, 16'h0, 24'h5678);
      op(1, 8'h72, 16'hffff, 24'h0);
      op(1, 8'h88, 16'h4142, 24'h30000);
      op(1, 8'h94, 16'h1, 24'h0);
      e = '0;
      for (i = 0; i < 8; i++) begin
         w[i] = rnd();
         e[127 - 16 * i -: 16] = w[i];
         op(1, 8'h88 + 8'(i), w[i], 24'h0);
      end
      op(1, 8'h94, 16'h2, 24'h0);
      e[7:0] = 8'h0;
      chk(liquidName, e);
      // Edits inside an aborted window must not reach the name
      op(1, 8'h94, 16'h1, 24'h0);
      op(1, 8'h88, 16'h5a5a, 24'h0);
      op(1, 8'h94, 16'h4, 24'h30000);
      op(1, 8'h94, 16'h3, 24'h0);
      chk(liquidName, e);
      op(1, 8'h96, 16'hf8, 24'h30000);
      chk(busAddress, 1);
      op(1, 8'h97, 16'h1, 24'h0);
      chk(labMode, 1);
      op(1, 8'h79, 16'h0, 24'h0);
      op(1, 8'hc9, w[1], 24'h0);
      chk(ownerText, 0);
      op(1, 8'hd2, w[2], 24'h0);
      @(negedge clock);
      chk(ownerText, {w[1], 128'h0, w[2][15:8], 8'h0});
      op(0, 8'hc9, 16'h0, {8'h0, w[1]});
      op(1, 8'hc5, 16'h1, 24'h0);
      repeat (3) @(negedge clock);
      chk(ownerText, 0);
      chk(serialBitRate, 3);
      for (i = 0; i < 9 && q.size() > 0; i++) @(negedge clock);
      if (q.size() > 0) chk(0, 1);
      stop_test();
   end
endmodule
